// file: pmadp_adapter.v
// processor memory path adapter: route decode, write-concurrency guard, apb registers
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pmadp_consts.vh"
// Summary of operation
// - ddr traffic uses low-latency path, interleaved across two memory controllers
// - non-ddr addresses go to the system interconnect path via bridge
// - controller/mapper registers and tiled ddr also use interconnect path
// - concurrent writes on both paths must never deadlock the adapter
// - tuning register; bits 2 and 1 set reduce lockup probability
// - tuning register answers at its address outside cluster space
module pmadp_adapter #(
   parameter CW = 4,
   parameter IL_BIT = 7
) (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // processor request
   input wire req_valid,
   input wire req_write,
   input wire [31:0] req_addr,
   output wire req_ready,
   // low-latency path, controller 0
   output reg ll0_valid,
   output reg ll0_write,
   output reg [31:0] ll0_addr,
   input wire ll0_ready,
   input wire ll0_wdone,
   // low-latency path, controller 1
   output reg ll1_valid,
   output reg ll1_write,
   output reg [31:0] ll1_addr,
   input wire ll1_ready,
   input wire ll1_wdone,
   // interconnect path through the bridge
   output reg ic_valid,
   output reg ic_write,
   output reg [31:0] ic_addr,
   input wire ic_ready,
   input wire ic_wdone
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [31:0] tuning_q;
   reg [31:0] ddr_base_q;
   reg [31:0] ddr_limit_q;
   reg [31:0] tiled_base_q;
   reg [31:0] tiled_limit_q;
   reg [31:0] ctrl_base_q;
   reg [31:0] ctrl_limit_q;
   reg [31:0] stall_cnt_q;
   wire wr_en;
   wire rd_en;
   reg hit;
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   // read data is loaded in the setup cycle so it already stands at the pready edge
   assign rd_en = psel && !penable && !pwrite;
   always @*
   begin
      case (paddr)
         `PMADP_TUNING_ADDR, `PMADP_STATUS_ADDR, `PMADP_DDR_BASE_ADDR, `PMADP_DDR_LIMIT_ADDR,
         `PMADP_TILED_BASE_ADDR, `PMADP_TILED_LIMIT_ADDR, `PMADP_CTRL_BASE_ADDR,
         `PMADP_CTRL_LIMIT_ADDR: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !hit;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tuning_q <= `PMADP_TUNING_RST;
         ddr_base_q <= `PMADP_DDR_BASE_RST;
         ddr_limit_q <= `PMADP_DDR_LIMIT_RST;
         tiled_base_q <= `PMADP_TILED_BASE_RST;
         tiled_limit_q <= `PMADP_TILED_LIMIT_RST;
         ctrl_base_q <= `PMADP_CTRL_BASE_RST;
         ctrl_limit_q <= `PMADP_CTRL_LIMIT_RST;
      end
      else if (wr_en)
      begin
         case (paddr)
            `PMADP_TUNING_ADDR: tuning_q <= pwdata;
            `PMADP_DDR_BASE_ADDR: ddr_base_q <= pwdata;
            `PMADP_DDR_LIMIT_ADDR: ddr_limit_q <= pwdata;
            `PMADP_TILED_BASE_ADDR: tiled_base_q <= pwdata;
            `PMADP_TILED_LIMIT_ADDR: tiled_limit_q <= pwdata;
            `PMADP_CTRL_BASE_ADDR: ctrl_base_q <= pwdata;
            `PMADP_CTRL_LIMIT_ADDR: ctrl_limit_q <= pwdata;
            default: tuning_q <= tuning_q;
         endcase
      end
   end
   // ----------------------------------------
   // path decode
   // ----------------------------------------
   wire in_ddr;
   wire in_tiled;
   wire in_ctrl;
   wire go_ic;
   wire ctrl_sel;
   assign in_ddr = (req_addr >= ddr_base_q) && (req_addr <= ddr_limit_q);
   assign in_tiled = (req_addr >= tiled_base_q) && (req_addr <= tiled_limit_q);
   assign in_ctrl = (req_addr >= ctrl_base_q) && (req_addr <= ctrl_limit_q);
   assign go_ic = !in_ddr || in_tiled || in_ctrl ? `PMADP_PATH_IC : `PMADP_PATH_LL;
   assign ctrl_sel = req_addr[IL_BIT];
   // ----------------------------------------
   // write-concurrency guard
   // ----------------------------------------
   // a write may not enter one path while writes are outstanding on the other;
   // with serial mode on this holds for reads too, with drain mode writes wait
   // until their own path has retired too, trading bandwidth for safety
   wire ll0_busy;
   wire ll1_busy;
   wire ic_busy;
   wire ll0_full;
   wire ll1_full;
   wire ic_full;
   wire ll_busy;
   wire serial_on;
   wire drain_on;
   wire blocked;
   wire out_busy;
   wire tgt_full;
   wire take;
   assign ll_busy = ll0_busy || ll1_busy;
   assign serial_on = tuning_q[`PMADP_TUNE_SERIAL_BIT];
   assign drain_on = tuning_q[`PMADP_TUNE_DRAIN_BIT];
   assign blocked = (req_write || serial_on) && (go_ic ? ll_busy : ic_busy);
   assign tgt_full = go_ic ? ic_full : (ctrl_sel ? ll1_full : ll0_full);
   assign out_busy = (ll0_valid && !ll0_ready) || (ll1_valid && !ll1_ready) || (ic_valid && !ic_ready);
   assign take = req_valid && !blocked && !tgt_full && !out_busy
      && !(drain_on && req_write && (go_ic ? ic_busy : ll_busy));
   assign req_ready = take;
   pmadp_port #(.CW(CW)) u_ll0 (
      .pclk(pclk),
      .presetn(presetn),
      .issue(take && req_write && !go_ic && !ctrl_sel),
      .retire(ll0_wdone),
      .busy(ll0_busy),
      .full(ll0_full)
   );
   pmadp_port #(.CW(CW)) u_ll1 (
      .pclk(pclk),
      .presetn(presetn),
      .issue(take && req_write && !go_ic && ctrl_sel),
      .retire(ll1_wdone),
      .busy(ll1_busy),
      .full(ll1_full)
   );
   pmadp_port #(.CW(CW)) u_ic (
      .pclk(pclk),
      .presetn(presetn),
      .issue(take && req_write && go_ic),
      .retire(ic_wdone),
      .busy(ic_busy),
      .full(ic_full)
   );
   // ----------------------------------------
   // forwarding registers
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ll0_valid <= 1'b0;
         ll1_valid <= 1'b0;
         ic_valid <= 1'b0;
         ll0_write <= 1'b0;
         ll1_write <= 1'b0;
         ic_write <= 1'b0;
         ll0_addr <= 32'h00000000;
         ll1_addr <= 32'h00000000;
         ic_addr <= 32'h00000000;
         stall_cnt_q <= 32'h00000000;
      end
      else
      begin
         if (ll0_valid && ll0_ready)
            ll0_valid <= 1'b0;
         if (ll1_valid && ll1_ready)
            ll1_valid <= 1'b0;
         if (ic_valid && ic_ready)
            ic_valid <= 1'b0;
         if (req_valid && blocked)
            stall_cnt_q <= stall_cnt_q + 32'h00000001;
         if (take)
         begin
            if (go_ic)
            begin
               ic_valid <= 1'b1;
               ic_write <= req_write;
               ic_addr <= req_addr;
            end
            else if (ctrl_sel)
            begin
               ll1_valid <= 1'b1;
               ll1_write <= req_write;
               ll1_addr <= req_addr;
            end
            else
            begin
               ll0_valid <= 1'b1;
               ll0_write <= req_write;
               ll0_addr <= req_addr;
            end
         end
      end
   end
   // ----------------------------------------
   // read data
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (rd_en)
      begin
         case (paddr)
            `PMADP_TUNING_ADDR: prdata <= tuning_q;
            `PMADP_STATUS_ADDR: prdata <= {stall_cnt_q[27:0], ic_busy, ll1_busy, ll0_busy, blocked};
            `PMADP_DDR_BASE_ADDR: prdata <= ddr_base_q;
            `PMADP_DDR_LIMIT_ADDR: prdata <= ddr_limit_q;
            `PMADP_TILED_BASE_ADDR: prdata <= tiled_base_q;
            `PMADP_TILED_LIMIT_ADDR: prdata <= tiled_limit_q;
            `PMADP_CTRL_BASE_ADDR: prdata <= ctrl_base_q;
            `PMADP_CTRL_LIMIT_ADDR: prdata <= ctrl_limit_q;
            default: prdata <= 32'h00000000;
         endcase
      end
   end
endmodule // pmadp_adapter
`default_nettype wire

// file: pmadp_adapter_monitor.sv
// checker of routing, liveness and register answers of the path adapter
`timescale 1ns/1ps
`default_nettype none
`include "pmadp_consts.vh"
module pmadp_adapter_monitor #(
   parameter IL_BIT = 7
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb
   input wire psel,
   input wire penable,
   input wire [31:0] paddr,
   input wire pready,
   input wire pslverr,
   // request and paths
   input wire req_valid,
   input wire [31:0] req_addr,
   input wire req_ready,
   input wire ll0_valid,
   input wire [31:0] ll0_addr,
   input wire ll1_valid,
   input wire [31:0] ll1_addr,
   input wire ic_valid,
   input wire [31:0] ic_addr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire take = req_valid && req_ready;
   wire tiled = req_addr >= `PMADP_TILED_BASE_RST && req_addr <= `PMADP_TILED_LIMIT_RST;
   wire ddr = req_addr >= `PMADP_DDR_BASE_RST && !tiled;
   AST_LL0: assert property (take && ddr && !req_addr[IL_BIT] |=> ll0_valid && ll0_addr == $past(req_addr))
      else $error("ddr request missed controller 0");
   AST_LL1: assert property (take && ddr && req_addr[IL_BIT] |=> ll1_valid && ll1_addr == $past(req_addr))
      else $error("ddr request missed controller 1");
   AST_IC: assert property (take && req_addr < `PMADP_DDR_BASE_RST |=> ic_valid && ic_addr == $past(req_addr))
      else $error("non-ddr request missed interconnect");
   AST_TILED: assert property (take && tiled |=> ic_valid && !ll0_valid && !ll1_valid)
      else $error("tiled request not on interconnect");
   AST_ONE: assert property (take |=> $onehot({ll0_valid, ll1_valid, ic_valid}))
      else $error("request not on exactly one path");
   AST_LIVE: assert property (req_valid |-> ##[0:300] req_ready)
      else $error("request stuck");
   AST_TUNE: assert property (psel && penable && paddr == `PMADP_TUNING_ADDR |-> pready && !pslverr)
      else $error("tuning register not answering");
   AST_ERR: assert property (psel && penable && paddr[31:12] != 20'h482af |-> pslverr)
      else $error("unmapped access without error");
   AST_IDLE: assert property (!(psel && penable) |-> !pslverr)
      else $error("error outside access phase");
endmodule // pmadp_adapter_monitor
bind pmadp_adapter pmadp_adapter_monitor #(.IL_BIT(IL_BIT)) u_mon (.*);
`default_nettype wire

// file: pmadp_consts.vh
// constants for the processor memory path adapter
`ifndef PMADP_CONSTS_VH
`define PMADP_CONSTS_VH
// ----------------------------------------
// register map (byte address, all 32 bits decoded)
// ----------------------------------------
`define PMADP_TUNING_ADDR 32'h482af400
`define PMADP_STATUS_ADDR 32'h482af404
`define PMADP_DDR_BASE_ADDR 32'h482af408
`define PMADP_DDR_LIMIT_ADDR 32'h482af40c
`define PMADP_TILED_BASE_ADDR 32'h482af410
`define PMADP_TILED_LIMIT_ADDR 32'h482af414
`define PMADP_CTRL_BASE_ADDR 32'h482af418
`define PMADP_CTRL_LIMIT_ADDR 32'h482af41c
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PMADP_TUNING_RST 32'h00000000
`define PMADP_TUNE_SERIAL_BIT 1
`define PMADP_TUNE_DRAIN_BIT 2
`define PMADP_DDR_BASE_RST 32'h80000000
`define PMADP_DDR_LIMIT_RST 32'hffffffff
`define PMADP_TILED_BASE_RST 32'hb0000000
`define PMADP_TILED_LIMIT_RST 32'hbfffffff
`define PMADP_CTRL_BASE_RST 32'h4c000000
`define PMADP_CTRL_LIMIT_RST 32'h4effffff
`define PMADP_PATH_LL 1'b0
`define PMADP_PATH_IC 1'b1
`endif

// file: pmadp_path_model.sv
// far-side model of one downstream path: stalling accept, delayed write completion
`timescale 1ns/1ps
`default_nettype none
module pmadp_path_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // request from the adapter, stall control from the bench
   input wire logic valid,
   input wire logic write,
   input wire logic stall,
   // answers
   output logic ready,
   output logic wdone
);
   logic [5:0] dly_q;
   // completion lags the accept so writes stay outstanding across requests
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ready <= 1'b0;
         dly_q <= 6'h00;
      end
      else
      begin
         ready <= stall ? ($urandom % 2 == 0) : 1'b1;
         dly_q <= {dly_q[4:0], valid && ready && write};
      end
   assign wdone = dly_q[5];
endmodule // pmadp_path_model
`default_nettype wire

// file: pmadp_port.v
// one downstream path port: outstanding write counter and forwarding gate
`timescale 1ns/1ps
`default_nettype none
module pmadp_port #(
   parameter CW = 4
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // events
   input wire issue,
   input wire retire,
   // state
   output wire busy,
   output wire full
);
   reg [CW-1:0] cnt_q;
   reg [CW-1:0] cnt_d;
   always @*
   begin
      cnt_d = cnt_q;
      if (issue && !retire)
         cnt_d = cnt_q + {{(CW-1){1'b0}}, 1'b1};
      else if (retire && !issue && cnt_q != {CW{1'b0}})
         cnt_d = cnt_q - {{(CW-1){1'b0}}, 1'b1};
   end
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= {CW{1'b0}};
      else
         cnt_q <= cnt_d;
   end
   assign busy = (cnt_q != {CW{1'b0}});
   assign full = (cnt_q == {CW{1'b1}});
endmodule // pmadp_port
`default_nettype wire

// file: test_pmadp_adapter.sv
// self-checking bench for the path adapter
`timescale 1ns/1ps
`default_nettype none
`include "pmadp_consts.vh"
module test_pmadp_adapter;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic req_valid = 1'b0, req_write = 1'b0, stall = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, req_addr = 32'h0;
   localparam int IL = 7;
   wire [31:0] prdata, ll0_addr, ll1_addr, ic_addr;
   wire pready, pslverr, req_ready, ll0_valid, ll0_write, ll1_valid, ll1_write, ic_valid, ic_write;
   wire ll0_ready, ll1_ready, ic_ready, ll0_wdone, ll1_wdone, ic_wdone;
   int n_errors = 0, n_checks = 0, n, k;
   logic [32:0] qa[$];
   logic [32:0] qp[3][$];
   always #25 pclk = ~pclk;
   pmadp_adapter DUT (.*);
   pmadp_path_model m0 (.pclk(pclk), .presetn(presetn), .valid(ll0_valid), .write(ll0_write), .stall(stall),
      .ready(ll0_ready), .wdone(ll0_wdone));
   pmadp_path_model m1 (.pclk(pclk), .presetn(presetn), .valid(ll1_valid), .write(ll1_write), .stall(stall),
      .ready(ll1_ready), .wdone(ll1_wdone));
   pmadp_path_model m2 (.pclk(pclk), .presetn(presetn), .valid(ic_valid), .write(ic_write), .stall(stall),
      .ready(ic_ready), .wdone(ic_wdone));
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // an empty queue yields an unknown note, which never matches
   task automatic chk_apb(input logic [32:0] g);
      logic [32:0] e;
      e = qa.size() ? qa.pop_front() : 33'bx;
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value apb expected %h seen %h", e, g);
      end
   endtask
   task automatic chk_path(input int i, input logic [32:0] g);
      logic [32:0] e;
      e = qp[i].size() ? qp[i].pop_front() : 33'bx;
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value path%0d expected %h seen %h", i, e, g);
      end
   endtask
   task automatic hang;
      n_errors++;
      summarize();
   endtask
   function automatic int pathof(input logic [31:0] x);
      if (x < `PMADP_DDR_BASE_RST || (x >= `PMADP_TILED_BASE_RST && x <= `PMADP_TILED_LIMIT_RST)
         || (x >= `PMADP_CTRL_BASE_RST && x <= `PMADP_CTRL_LIMIT_RST))
         return 2;
      return x[IL] ? 1 : 0;
   endfunction
   // ----------------------------------------
   // drivers
   // ----------------------------------------
   // read expectation is {pslverr, prdata}, write expectation {pslverr, 0}
   task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d, input logic [32:0] e);
      qa.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++)
      begin
         @(posedge pclk);
         if (pready)
            break;
      end
      if (k == 20)
         hang();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic req(input logic [31:0] ad, input logic w);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= ad;
      for (k = 0; k < 400; k++)
      begin
         @(posedge pclk);
         if (req_ready)
            break;
      end
      if (k == 400)
         hang();
      qp[pathof(ad)].push_back({w, ad});
      req_valid <= 1'b0;
      @(posedge pclk);
   endtask
   // waits until every forwarded transfer is accepted and its completion is back
   task automatic drain;
      for (k = 0; k < 400 && (qp[0].size() + qp[1].size() + qp[2].size()) > 0; k++)
         @(posedge pclk);
      if (k == 400)
         hang();
      repeat (8) @(posedge pclk);
   endtask
   // ----------------------------------------
   // result watchers
   // ----------------------------------------
   always @(posedge pclk)
      if (presetn && psel && penable && pready)
         chk_apb({pslverr, pwrite ? 32'h0 : prdata});
   always @(posedge pclk)
      if (presetn)
      begin
         if (ll0_valid && ll0_ready)
            chk_path(0, {ll0_write, ll0_addr});
         if (ll1_valid && ll1_ready)
            chk_path(1, {ll1_write, ll1_addr});
         if (ic_valid && ic_ready)
            chk_path(2, {ic_write, ic_addr});
      end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'hed2f));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `PMADP_TUNING_ADDR, 32'h0, {1'b0, `PMADP_TUNING_RST});
      apb(1'b0, `PMADP_DDR_BASE_ADDR, 32'h0, {1'b0, `PMADP_DDR_BASE_RST});
      apb(1'b0, 32'h482b0000, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 32'h00001000, $urandom, {1'b1, 32'h0});
      req(32'h80000000, 1'b1);
      req(32'h80000080, 1'b1);
      req(32'hb0000040, 1'b1);
      req(32'h4c000010, 1'b1);
      req(32'h00001000, 1'b0);
      drain();
      req(32'h4c000020, 1'b1);
      for (n = 0; n < 80; n++)
      begin
         stall <= 1'($urandom % 2);
         req($urandom, 1'($urandom % 2));
      end
      drain();
      apb(1'b1, `PMADP_TUNING_ADDR, 32'h6, 33'h0);
      apb(1'b0, `PMADP_TUNING_ADDR, 32'h0, {1'b0, 32'h6});
      for (n = 0; n < 80; n++)
      begin
         stall <= 1'($urandom % 2);
         req($urandom, 1'($urandom % 2));
      end
      drain();
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `PMADP_TUNING_ADDR, 32'h0, {1'b0, `PMADP_TUNING_RST});
      req(32'h80000000, 1'b1);
      drain();
      summarize();
   end
endmodule // test_pmadp_adapter
`default_nettype wire
